/* File: mpr_consts.vh */
// MIDI parameter router constants
// Operation
// - Panel destination: internal, internal plus MIDI, MIDI only
// - Internal only: panel changes reach generator, none sent on MIDI
// - Internal plus MIDI or MIDI only: panel changes sent on MIDI
// - MIDI only: panel changes reach generator only when echoed back
// - Three pages of at most 128 parameters each
// - First page travels as control change, both ways
// - Second page travels as key pressure, fields as control change
// - First and second pages form one single-sound program
// - Shared channel: only lowest-numbered part takes sound parameters
// - Performance controllers reach every part on the channel
// - Per-page system-exclusive enable makes it the only way in
// - Third page, multi and global settings, only by system exclusive
// - System exclusive addresses one part directly, whatever its channel
// - Two transports: lower page suggested control change, upper key pressure
`ifndef MPR_CONSTS_VH
`define MPR_CONSTS_VH

`define MPR_ADDR_CONFIG  8'h00
`define MPR_ADDR_CHAN    8'h04
`define MPR_ADDR_STATUS  8'h08
`define MPR_ADDR_DROPS   8'h0c

`define MPR_CFG_DEST_LSB 0
`define MPR_CFG_DEST_MSB 1
`define MPR_CFG_LOTR     2
`define MPR_CFG_HITR     3
`define MPR_CFG_SX1      4
`define MPR_CFG_SX2      5
`define MPR_STATUS_TXPND 16

`define MPR_DEST_INT      2'h0
`define MPR_DEST_INT_MIDI 2'h1
`define MPR_DEST_MIDI     2'h2
`define MPR_DEST_RESET    2'h0

`define MPR_TR_CC        1'b0
`define MPR_TR_KP        1'b1
`define MPR_LOTR_RESET   1'b0
`define MPR_HITR_RESET   1'b1

`define MPR_ST_CC        4'hb
`define MPR_ST_KP        4'ha

`define MPR_PAGE_PERF    2'h0
`define MPR_PAGE1        2'h1
`define MPR_PAGE2        2'h2
`define MPR_PAGE3        2'h3
`define MPR_PAGE_SIZE    128

`define MPR_CC_MODWHEEL  7'h01
`define MPR_CC_BREATH    7'h02
`define MPR_CC_FOOT      7'h04
`define MPR_CC_SUSTAIN   7'h40

`endif

/* File: mpr_msg_class.v */
// Classifies an incoming channel message into a parameter page
`timescale 1ns/1ps
`default_nettype none
`include "mpr_consts.vh"
module mpr_msg_class (
   input  wire [7:0] status,   // Status byte
   input  wire [6:0] number,   // First data byte
   input  wire       lotr,     // Lower page transport
   input  wire       hitr,     // Upper page transport
   input  wire       sx1_en,   // Page 1 system exclusive only
   input  wire       sx2_en,   // Page 2 system exclusive only
   output reg  [1:0] page,     // Page code
   output reg        valid,    // Message carries a parameter
   output reg        locked,   // Page is system exclusive only
   output wire [3:0] chan      // Channel nibble
);
   reg kind_cc;
   reg kind_kp;
   reg perf;
   reg lo;
   reg hi;

   function is_perf;
      input [6:0] n;
      begin
         is_perf = (n == `MPR_CC_MODWHEEL) | (n == `MPR_CC_BREATH) |
                   (n == `MPR_CC_FOOT) | (n == `MPR_CC_SUSTAIN);
      end
   endfunction

   assign chan = status[3:0];

   always @* begin
      kind_cc = (status[7:4] == `MPR_ST_CC);
      kind_kp = (status[7:4] == `MPR_ST_KP);
      perf    = kind_cc & is_perf(number);
      lo      = (lotr == `MPR_TR_CC) ? kind_cc : kind_kp;
      hi      = (hitr == `MPR_TR_CC) ? kind_cc : kind_kp;
      // Lower page wins if both transports name the same message type
      page    = perf ? `MPR_PAGE_PERF : (lo ? `MPR_PAGE1 : `MPR_PAGE2);
      valid   = perf | lo | hi;
      locked  = ~perf & (lo ? sx1_en : sx2_en);
   end
endmodule
`default_nettype wire

/* File: mpr_part_pick.v */
// Finds the parts listening on a channel and the lowest of them
`timescale 1ns/1ps
`default_nettype none
module mpr_part_pick #(
   parameter NUM_PARTS = 4
) (
   input  wire [3:0]             chan,      // Channel of the message
   input  wire [4*NUM_PARTS-1:0] chan_map,  // Receive channel of each part
   output wire [NUM_PARTS-1:0]   all_mask,  // Every matching part
   output wire [NUM_PARTS-1:0]   low_mask,  // Lowest matching part only
   output wire                   hit        // At least one part matches
);
   genvar g;
   generate
      for (g = 0; g < NUM_PARTS; g = g + 1) begin : g_match
         assign all_mask[g] = (chan_map[4*g +: 4] == chan);
      end
   endgenerate

   // Isolating the lowest set bit needs no priority chain
   assign low_mask = all_mask & (~all_mask + {{(NUM_PARTS-1){1'b0}}, 1'b1});
   assign hit      = |all_mask;
endmodule
`default_nettype wire

/* File: mpr_router.v */
// MIDI parameter router: panel, MIDI and system-exclusive paths to the generator
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mpr_consts.vh"
module mpr_router #(
   parameter NUM_PARTS = 4,
   parameter PART_W    = 2
) (
   input  wire                 clock,        // 40 MHz clock
   input  wire                 srst,         // Synchronous reset, active high
   input  wire [7:0]           reg_addr,     // Register byte address
   input  wire [31:0]          reg_wdata,    // Register write data
   input  wire                 reg_wr,       // Write strobe
   input  wire                 reg_rd,       // Read strobe
   output reg  [31:0]          reg_rdata,    // Read data, cycle after strobe
   input  wire                 panel_valid,  // Knob or button change offered
   output reg                  panel_ready,  // Panel change taken
   input  wire [PART_W-1:0]    panel_part,   // Part being edited
   input  wire                 panel_page,   // 0 first page, 1 second page
   input  wire [6:0]           panel_param,  // Parameter number
   input  wire [6:0]           panel_value,  // Parameter value
   input  wire                 rx_valid,     // Parsed channel message offered
   output reg                  rx_ready,     // Channel message taken
   input  wire [7:0]           rx_status,    // Status byte
   input  wire [6:0]           rx_data1,     // Number byte
   input  wire [6:0]           rx_data2,     // Value byte
   input  wire                 sx_valid,     // System exclusive parameter, always taken
   input  wire [PART_W-1:0]    sx_part,      // Target part
   input  wire [1:0]           sx_page,      // Page 1 to 3, 0 ignored
   input  wire [6:0]           sx_param,     // Parameter number
   input  wire [6:0]           sx_value,     // Parameter value
   output reg                  tx_valid,     // Outgoing message ready
   input  wire                 tx_ready,     // Transmitter takes message
   output reg  [7:0]           tx_status,    // Outgoing status byte
   output reg  [6:0]           tx_data1,     // Outgoing number byte
   output reg  [6:0]           tx_data2,     // Outgoing value byte
   output reg                  gen_valid,    // Generator update pulse
   output reg  [NUM_PARTS-1:0] gen_mask,     // Parts that take the update
   output reg  [1:0]           gen_page,     // Page code, 0 performance controller
   output reg  [6:0]           gen_param,    // Parameter number
   output reg  [6:0]           gen_value     // Parameter value
);
   // Configuration and status
   reg  [1:0]             dest_q;
   reg                    lotr_q;
   reg                    hitr_q;
   reg                    sx1_q;
   reg                    sx2_q;
   reg  [4*NUM_PARTS-1:0] chan_q;
   reg  [NUM_PARTS-1:0]   edited_q;
   reg  [7:0]             drops_q;

   // Next values
   reg                    gen_valid_d;
   reg  [NUM_PARTS-1:0]   gen_mask_d;
   reg  [1:0]             gen_page_d;
   reg  [6:0]             gen_param_d;
   reg  [6:0]             gen_value_d;
   reg  [NUM_PARTS-1:0]   edited_d;
   reg  [7:0]             drops_d;
   reg  [31:0]            rdata_d;

   // Path selection
   reg                    sel_sx;
   reg                    sel_rx;
   reg                    sel_pn;
   reg                    pn_gen;
   reg                    pn_tx;
   reg                    pn_tr;
   reg                    rx_apply;
   reg                    rx_drop;
   reg  [NUM_PARTS-1:0]   rx_mask;
   reg  [NUM_PARTS-1:0]   clr_mask;
   reg  [3:0]             pn_chan;

   wire [1:0]             cls_page;
   wire                   cls_valid;
   wire                   cls_locked;
   wire [3:0]             cls_chan;
   wire [NUM_PARTS-1:0]   all_mask;
   wire [NUM_PARTS-1:0]   low_mask;
   wire                   hit;
   wire                   wr_cfg;
   wire                   wr_status;
   wire                   wr_drops;

   function dest_gen;
      input [1:0] d;
      begin
         // Reserved code 3 behaves as internal only
         dest_gen = (d != `MPR_DEST_MIDI);
      end
   endfunction

   function dest_tx;
      input [1:0] d;
      begin
         dest_tx = (d == `MPR_DEST_INT_MIDI) | (d == `MPR_DEST_MIDI);
      end
   endfunction

   function [NUM_PARTS-1:0] onehot;
      input [PART_W-1:0] p;
      integer k;
      begin
         onehot = {NUM_PARTS{1'b0}};
         for (k = 0; k < NUM_PARTS; k = k + 1) begin
            if (p == k[PART_W-1:0]) begin
               onehot[k] = 1'b1;
            end
         end
      end
   endfunction

   assign wr_cfg    = reg_wr & (reg_addr == `MPR_ADDR_CONFIG);
   assign wr_status = reg_wr & (reg_addr == `MPR_ADDR_STATUS);
   assign wr_drops  = reg_wr & (reg_addr == `MPR_ADDR_DROPS);

   mpr_msg_class u_class (
      .status (rx_status),
      .number (rx_data1),
      .lotr   (lotr_q),
      .hitr   (hitr_q),
      .sx1_en (sx1_q),
      .sx2_en (sx2_q),
      .page   (cls_page),
      .valid  (cls_valid),
      .locked (cls_locked),
      .chan   (cls_chan)
   );

   mpr_part_pick #(
      .NUM_PARTS (NUM_PARTS)
   ) u_pick (
      .chan     (cls_chan),
      .chan_map (chan_q),
      .all_mask (all_mask),
      .low_mask (low_mask),
      .hit      (hit)
   );

   // Path arbitration: system exclusive first, then MIDI input, then panel
   always @* begin
      pn_gen      = dest_gen(dest_q);
      pn_tx       = dest_tx(dest_q);
      pn_tr       = panel_page ? hitr_q : lotr_q;
      pn_chan     = chan_q[4*panel_part +: 4];
      sel_sx      = sx_valid & (sx_page != `MPR_PAGE_PERF);
      rx_ready    = ~sx_valid;
      sel_rx      = rx_valid & ~sx_valid;
      // A panel change that must go out waits while the transmitter holds one
      panel_ready = ~sx_valid & ~rx_valid & (~pn_tx | ~tx_valid | tx_ready);
      sel_pn      = panel_valid & panel_ready;
      rx_mask     = (cls_page == `MPR_PAGE_PERF) ? all_mask : low_mask;
      rx_apply    = sel_rx & cls_valid & ~cls_locked & hit;
      rx_drop     = sel_rx & cls_valid & (cls_locked | ~hit);
   end

   always @* begin
      gen_valid_d = 1'b0;
      gen_mask_d  = gen_mask;
      gen_page_d  = gen_page;
      gen_param_d = gen_param;
      gen_value_d = gen_value;
      if (sel_sx) begin
         // Direct part address ignores channel assignment
         gen_valid_d = 1'b1;
         gen_mask_d  = onehot(sx_part);
         gen_page_d  = sx_page;
         gen_param_d = sx_param;
         gen_value_d = sx_value;
      end else if (rx_apply) begin
         // Echoed panel data in MIDI-only mode lands here
         gen_valid_d = 1'b1;
         gen_mask_d  = rx_mask;
         gen_page_d  = cls_page;
         gen_param_d = rx_data1;
         gen_value_d = rx_data2;
      end else if (sel_pn & pn_gen) begin
         gen_valid_d = 1'b1;
         gen_mask_d  = onehot(panel_part);
         gen_page_d  = panel_page ? `MPR_PAGE2 : `MPR_PAGE1;
         gen_param_d = panel_param;
         gen_value_d = panel_value;
      end
   end

   // Program-edited flags: a new edit in the clearing cycle survives
   always @* begin
      clr_mask = wr_status ? reg_wdata[NUM_PARTS-1:0] : {NUM_PARTS{1'b0}};
      edited_d = edited_q & ~clr_mask;
      if (gen_valid_d & ((gen_page_d == `MPR_PAGE1) | (gen_page_d == `MPR_PAGE2))) begin
         edited_d = edited_d | gen_mask_d;
      end
   end

   always @* begin
      drops_d = wr_drops ? 8'h00 : drops_q;
      if (rx_drop & (drops_q != 8'hff)) begin
         drops_d = drops_q + 8'h01;
      end
   end

   always @* begin
      rdata_d = 32'h0000_0000;
      case (reg_addr)
         `MPR_ADDR_CONFIG: begin
            rdata_d[`MPR_CFG_DEST_MSB:`MPR_CFG_DEST_LSB] = dest_q;
            rdata_d[`MPR_CFG_LOTR] = lotr_q;
            rdata_d[`MPR_CFG_HITR] = hitr_q;
            rdata_d[`MPR_CFG_SX1]  = sx1_q;
            rdata_d[`MPR_CFG_SX2]  = sx2_q;
         end
         `MPR_ADDR_CHAN: begin
            rdata_d[4*NUM_PARTS-1:0] = chan_q;
         end
         `MPR_ADDR_STATUS: begin
            rdata_d[NUM_PARTS-1:0]     = edited_q;
            rdata_d[`MPR_STATUS_TXPND] = tx_valid;
         end
         `MPR_ADDR_DROPS: begin
            rdata_d[7:0] = drops_q;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clock) begin
      if (srst) begin
         dest_q <= `MPR_DEST_RESET;
         lotr_q <= `MPR_LOTR_RESET;
         hitr_q <= `MPR_HITR_RESET;
         sx1_q  <= 1'b0;
         sx2_q  <= 1'b0;
      end else if (wr_cfg) begin
         dest_q <= reg_wdata[`MPR_CFG_DEST_MSB:`MPR_CFG_DEST_LSB];
         lotr_q <= reg_wdata[`MPR_CFG_LOTR];
         hitr_q <= reg_wdata[`MPR_CFG_HITR];
         sx1_q  <= reg_wdata[`MPR_CFG_SX1];
         sx2_q  <= reg_wdata[`MPR_CFG_SX2];
      end
   end

   // One receive channel per part; part n starts on channel n
   genvar g;
   generate
      for (g = 0; g < NUM_PARTS; g = g + 1) begin : g_chan
         always @(posedge clock) begin
            if (srst) begin
               chan_q[4*g +: 4] <= g[3:0];
            end else if (reg_wr & (reg_addr == `MPR_ADDR_CHAN)) begin
               chan_q[4*g +: 4] <= reg_wdata[4*g +: 4];
            end
         end
      end
   endgenerate

   always @(posedge clock) begin
      if (srst) begin
         edited_q  <= {NUM_PARTS{1'b0}};
         drops_q   <= 8'h00;
         reg_rdata <= 32'h0000_0000;
      end else begin
         edited_q  <= edited_d;
         drops_q   <= drops_d;
         reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         gen_valid <= 1'b0;
         gen_mask  <= {NUM_PARTS{1'b0}};
         gen_page  <= `MPR_PAGE_PERF;
         gen_param <= 7'h00;
         gen_value <= 7'h00;
      end else begin
         gen_valid <= gen_valid_d;
         gen_mask  <= gen_mask_d;
         gen_page  <= gen_page_d;
         gen_param <= gen_param_d;
         gen_value <= gen_value_d;
      end
   end

   // Transmit holding register; the panel stalls rather than lose a message
   always @(posedge clock) begin
      if (srst) begin
         tx_valid  <= 1'b0;
         tx_status <= 8'h00;
         tx_data1  <= 7'h00;
         tx_data2  <= 7'h00;
      end else if (sel_pn & pn_tx) begin
         tx_valid  <= 1'b1;
         tx_status <= {(pn_tr == `MPR_TR_KP) ? `MPR_ST_KP : `MPR_ST_CC, pn_chan};
         tx_data1  <= panel_param;
         tx_data2  <= panel_value;
      end else if (tx_ready) begin
         tx_valid  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: mpr_router_monitor.sv */
// Assertion checker bound to the MIDI parameter router
`timescale 1ns/1ps
`default_nettype none
`include "mpr_consts.vh"
module mpr_router_monitor #(
   parameter NUM_PARTS = 4,
   parameter PART_W    = 2
) (
   input wire logic                 clock,       // Clock
   input wire logic                 srst,        // Reset
   input wire logic [7:0]           reg_addr,    // Address
   input wire logic [31:0]          reg_wdata,   // Write data
   input wire logic                 reg_wr,      // Write strobe
   input wire logic                 reg_rd,      // Read strobe
   input wire logic [31:0]          reg_rdata,   // Read data
   input wire logic                 panel_valid, // Panel offer
   input wire logic                 panel_ready, // Panel taken
   input wire logic [PART_W-1:0]    panel_part,  // Panel part
   input wire logic                 panel_page,  // Panel page
   input wire logic [6:0]           panel_param, // Panel number
   input wire logic [6:0]           panel_value, // Panel value
   input wire logic                 rx_valid,    // Rx offer
   input wire logic                 rx_ready,    // Rx taken
   input wire logic [7:0]           rx_status,   // Rx status
   input wire logic [6:0]           rx_data1,    // Rx number
   input wire logic                 sx_valid,    // Sysex pulse
   input wire logic [PART_W-1:0]    sx_part,     // Sysex part
   input wire logic [1:0]           sx_page,     // Sysex page
   input wire logic                 tx_valid,    // Tx offer
   input wire logic                 tx_ready,    // Tx taken
   input wire logic [7:0]           tx_status,   // Tx status
   input wire logic [6:0]           tx_data1,    // Tx number
   input wire logic [6:0]           tx_data2,    // Tx value
   input wire logic                 gen_valid,   // Generator pulse
   input wire logic [NUM_PARTS-1:0] gen_mask,    // Generator parts
   input wire logic [1:0]           gen_page,    // Generator page
   input wire logic [6:0]           gen_value    // Generator value
);
   logic [5:0] cfg_q;
   logic       take_p;
   logic       take_r;
   logic       perf;
   logic [1:0] dest;
   logic [3:0] lo_nib;
   logic [3:0] hi_nib;
   // Configuration shadow
   always @(posedge clock) begin
      if (srst)
         cfg_q <= 6'h08;
      else if (reg_wr && reg_addr == `MPR_ADDR_CONFIG)
         cfg_q <= reg_wdata[5:0];
   end
   assign take_p = panel_valid && panel_ready;
   assign take_r = rx_valid && rx_ready;
   assign dest   = cfg_q[1:0];
   assign lo_nib = cfg_q[2] ? `MPR_ST_KP : `MPR_ST_CC;
   assign hi_nib = cfg_q[3] ? `MPR_ST_KP : `MPR_ST_CC;
   assign perf   = rx_data1 == 7'h01 || rx_data1 == 7'h02 || rx_data1 == 7'h04 || rx_data1 == 7'h40;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read slot");
   a_unmapped_read: assert property (reg_rd && reg_addr > `MPR_ADDR_DROPS |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_panel_internal: assert property (take_p && (dest == 2'h0 || dest == 2'h3) |=> gen_valid && !tx_valid
      && gen_mask == (1 << $past(panel_part)) && gen_page == ($past(panel_page) ? 2'h2 : 2'h1)
      && gen_value == $past(panel_value)) else $error("internal panel change misrouted");
   a_panel_sends: assert property (take_p && (dest == 2'h1 || dest == 2'h2) |=> tx_valid
      && tx_data1 == $past(panel_param) && tx_data2 == $past(panel_value)
      && tx_status[7:4] == ($past(panel_page) ? hi_nib : lo_nib)) else $error("panel change not sent");
   a_panel_both: assert property (take_p && dest == 2'h1 |=> gen_valid && tx_valid)
      else $error("internal plus midi missed a path");
   a_midi_only: assert property (take_p && dest == 2'h2 |=> !gen_valid)
      else $error("midi only reached generator");
   a_sysex_direct: assert property (sx_valid && sx_page != 2'h0 |=> gen_valid
      && gen_mask == (1 << $past(sx_part)) && gen_page == $past(sx_page)) else $error("sysex update wrong");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_status)
      && $stable(tx_data1) && $stable(tx_data2)) else $error("tx message changed while waiting");
   a_sysex_lock: assert property (take_r && ((rx_status[7:4] == lo_nib && cfg_q[4])
      || (rx_status[7:4] == hi_nib && hi_nib != lo_nib && cfg_q[5])) |=> !gen_valid)
      else $error("locked page accepted");
   a_rx_lowest: assert property (take_r && rx_status[7:4] == `MPR_ST_CC && lo_nib == `MPR_ST_CC && !perf
      |=> !gen_valid || $onehot(gen_mask)) else $error("sound parameter reached several parts");
   a_perf_all: assert property (take_r && rx_status[7:4] == `MPR_ST_CC && lo_nib == `MPR_ST_CC
      && perf && !cfg_q[4] |=> !gen_valid || gen_page == `MPR_PAGE_PERF) else $error("performance page wrong");
   c_midi_only: cover property (take_p && dest == 2'h2);
   c_page3: cover property (sx_valid && sx_page == 2'h3);
   c_perf: cover property (take_r && perf);
endmodule
bind mpr_router mpr_router_monitor #(.NUM_PARTS(NUM_PARTS), .PART_W(PART_W)) mpr_router_monitor_inst (.*);
`default_nettype wire

/* File: mpr_seq_echo.sv */
// Sequencer model: slow taker with thru echo
`timescale 1ns/1ps
`default_nettype none
module mpr_seq_echo #(
   parameter STALL = 2
) (
   input  wire logic       clock,     // Clock
   input  wire logic       srst,      // Reset
   input  wire logic       echo_en,   // Thru function on
   input  wire logic       tx_valid,  // Message from router
   output wire logic       tx_ready,  // Taken after the stall
   input  wire logic [7:0] tx_status, // Status from router
   input  wire logic [6:0] tx_data1,  // Number from router
   input  wire logic [6:0] tx_data2,  // Value from router
   output var  logic       rx_valid,  // Echo offered
   input  wire logic       rx_ready,  // Echo taken
   output var  logic [7:0] rx_status, // Echo status
   output var  logic [6:0] rx_data1,  // Echo number
   output var  logic [6:0] rx_data2   // Echo value
);
   int wait_q;
   assign tx_ready = tx_valid && wait_q == STALL;
   always @(posedge clock) begin
      if (srst) begin
         wait_q    <= 0;
         rx_valid  <= 1'b0;
         rx_status <= 8'h00;
         rx_data1  <= 7'h00;
         rx_data2  <= 7'h00;
      end else begin
         wait_q <= (tx_valid && !tx_ready) ? wait_q + 1 : 0;
         if (tx_valid && tx_ready && echo_en) begin
            rx_valid  <= 1'b1;
            rx_status <= tx_status;
            rx_data1  <= tx_data1;
            rx_data2  <= tx_data2;
         end else if (rx_valid && rx_ready) begin
            // Released lines show the inverse
            rx_valid  <= 1'b0;
            rx_status <= ~rx_status;
            rx_data1  <= ~rx_data1;
            rx_data2  <= ~rx_data2;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb.sv */
// Testbench for the MIDI parameter router
`timescale 1ns/1ps
`default_nettype none
`include "mpr_consts.vh"
module tb;
   logic        clock, srst, reg_wr, reg_rd, panel_valid, panel_ready, panel_page, echo_en;
   logic [7:0]  reg_addr, t_status, p_status, rx_status, tx_status, t_last;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0]  panel_part, sx_part, sx_page, gen_page, g_page;
   logic [6:0]  panel_param, panel_value, t_d1, t_d2, p_d1, p_d2, rx_data1, rx_data2;
   logic [6:0]  sx_param, sx_value, tx_data1, tx_data2, gen_param, gen_value, g_val;
   logic        t_valid, p_valid, rx_valid, rx_ready, sx_valid, tx_valid, tx_ready, gen_valid;
   logic [3:0]  gen_mask, g_mask;
   int          fails = 0, checked = 0, gen_cnt = 0, tx_cnt = 0, n0, x0, i, d;
   localparam logic [28:0] ROWS [9] = '{
      {8'hb0, 7'h07, 7'h05, 1'h1, 4'h1, 2'h1}, {8'hb0, 7'h01, 7'h40, 1'h1, 4'h3, 2'h0},
      {8'hb0, 7'h02, 7'h41, 1'h1, 4'h3, 2'h0}, {8'hb0, 7'h04, 7'h42, 1'h1, 4'h3, 2'h0},
      {8'hb0, 7'h40, 7'h7f, 1'h1, 4'h3, 2'h0}, {8'ha0, 7'h09, 7'h11, 1'h1, 4'h1, 2'h2},
      {8'hb2, 7'h07, 7'h05, 1'h1, 4'h4, 2'h1}, {8'hb5, 7'h07, 7'h05, 1'h0, 4'h0, 2'h0},
      {8'h90, 7'h3c, 7'h40, 1'h0, 4'h0, 2'h0}};
   assign rx_valid = t_valid | p_valid;
   assign rx_status = t_valid ? t_status : p_status;
   assign rx_data1 = t_valid ? t_d1 : p_d1;
   assign rx_data2 = t_valid ? t_d2 : p_d2;
   mpr_router #(.NUM_PARTS(4), .PART_W(2)) mpr_router_inst (.*);
   mpr_seq_echo #(.STALL(2)) mpr_seq_echo_inst (.clock(clock), .srst(srst), .echo_en(echo_en),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_status(tx_status), .tx_data1(tx_data1),
      .tx_data2(tx_data2), .rx_valid(p_valid), .rx_ready(rx_ready & !t_valid), .rx_status(p_status),
      .rx_data1(p_d1), .rx_data2(p_d2));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (gen_valid === 1'b1) begin
         gen_cnt <= gen_cnt + 1;
         g_mask <= gen_mask;
         g_page <= gen_page;
         g_val <= gen_value;
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         tx_cnt <= tx_cnt + 1;
         t_last <= tx_status;
      end
   end
   task complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         fails++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      check(reg_rdata === e, "register read");
   endtask
   task rx(input logic [7:0] s, input logic [6:0] a, input logic [6:0] b);
      n0 = gen_cnt;
      @(posedge clock);
      {t_valid, t_status, t_d1, t_d2} <= {1'b1, s, a, b};
      @(posedge clock);
      {t_valid, t_status, t_d1, t_d2} <= {1'b0, ~s, ~a, ~b};
      repeat (3) @(posedge clock);
   endtask
   task sx(input logic [1:0] p, input logic [1:0] pg);
      n0 = gen_cnt;
      @(posedge clock);
      {sx_valid, sx_part, sx_page, sx_param, sx_value} <= {1'b1, p, pg, 7'h33, 7'h44};
      @(posedge clock);
      sx_valid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task gen_is(input logic v, input logic [3:0] m, input logic [1:0] pg, input logic [6:0] val);
      if (v)
         check(gen_cnt == n0 + 1 && g_mask === m && g_page === pg && g_val === val, "generator update");
      else
         check(gen_cnt == n0, "unexpected generator update");
   endtask
   initial begin
      {srst, reg_wr, reg_rd, panel_valid, t_valid, sx_valid, echo_en} = 7'h40;
      {reg_addr, reg_wdata, t_status, t_d1, t_d2} = '0;
      {panel_part, panel_page, panel_param, panel_value, sx_part, sx_page, sx_param, sx_value} = '0;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      rd(`MPR_ADDR_CONFIG, 32'h08);
      rd(`MPR_ADDR_CHAN, 32'h3210);
      rd(`MPR_ADDR_STATUS, 32'h0);
      rd(8'h10, 32'h0);
      wr(`MPR_ADDR_CHAN, 32'h3200);
      foreach (ROWS[k]) begin
         rx(ROWS[k][28:21], ROWS[k][20:14], ROWS[k][13:7]);
         gen_is(ROWS[k][6], ROWS[k][5:2], ROWS[k][1:0], ROWS[k][13:7]);
      end
      rd(`MPR_ADDR_DROPS, 32'h1);
      rd(`MPR_ADDR_STATUS, 32'h5);
      wr(`MPR_ADDR_STATUS, 32'hf);
      rd(`MPR_ADDR_STATUS, 32'h0);
      for (d = 0; d < 4; d++) begin
         wr(`MPR_ADDR_CONFIG, 32'h08 | d);
         echo_en <= (d == 2);
         n0 = gen_cnt;
         x0 = tx_cnt;
         @(posedge clock);
         {panel_valid, panel_part, panel_page, panel_param, panel_value} <= {1'b1, 2'h1, 1'b1, 7'h15, 7'h2a};
         for (i = 0; i < 20 && panel_ready !== 1'b1; i++) @(negedge clock);
         if (i == 20) begin
            fails++;
            complete_run;
         end
         @(posedge clock);
         panel_valid <= 1'b0;
         for (i = 0; i < 30 && gen_cnt == n0; i++) @(posedge clock);
         repeat (4) @(posedge clock);
         // Echo returns on channel 0: lowest part takes it
         gen_is(1'b1, (d == 2) ? 4'h1 : 4'h2, 2'h2, 7'h2a);
         check(tx_cnt == x0 + ((d == 1 || d == 2) ? 1 : 0), "panel transmit count");
         if (d == 1 || d == 2)
            check(t_last === 8'ha0, "panel status byte");
      end
      echo_en <= 1'b0;
      wr(`MPR_ADDR_CONFIG, 32'h18);
      rx(8'hb0, 7'h07, 7'h05);
      gen_is(1'b0, 4'h0, 2'h0, 7'h0);
      rx(8'ha0, 7'h09, 7'h11);
      gen_is(1'b1, 4'h1, 2'h2, 7'h11);
      sx(2'h3, 2'h1);
      gen_is(1'b1, 4'h8, 2'h1, 7'h44);
      sx(2'h2, 2'h3);
      gen_is(1'b1, 4'h4, 2'h3, 7'h44);
      rd(`MPR_ADDR_DROPS, 32'h2);
      wr(`MPR_ADDR_CONFIG, 32'h04);
      rx(8'ha0, 7'h07, 7'h05);
      gen_is(1'b1, 4'h1, 2'h1, 7'h05);
      rx(8'hb0, 7'h07, 7'h06);
      gen_is(1'b1, 4'h1, 2'h2, 7'h06);
      @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      rd(`MPR_ADDR_CONFIG, 32'h08);
      rd(`MPR_ADDR_CHAN, 32'h3210);
      rd(`MPR_ADDR_DROPS, 32'h0);
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      complete_run;
   end
endmodule
`default_nettype wire
